// [bench/capcomp_irq_enable_gating_test.sv]
`timescale 1ns/10ps
module capcomp_irq_enable_gating_test;
  import caprq_pkg::*;
  logic            aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic            bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0]     awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]     wdata = 32'h0, rdata, rd_d;
  logic [1:0]      bresp, rresp, rsp, p;
  logic            awready, wready, bvalid, arready, rvalid, irq;
  logic [3:0]      sl, sl_seen;
  logic [3:0]      wstrb = 4'hF;
  logic [7:0]      n_req;
  caprq_evt_t      evt = '0;
  caprq_line_sel_t lsel = '0;
  int              n_fail = 0, total_checks = 0;

  always #5 aclk = ~aclk;

  caprq_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hw_event_set(evt), .line_select(lsel), .service_line(sl), .irq(irq));

  caprq_req_sink u_sink (.aclk(aclk), .aresetn(aresetn), .service_line(sl), .n_req(n_req));

  task conclude;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ready is judged one step after the edge, so it is the value the next edge sees
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_go, w_go, b_go;
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    sl_seen = 4'h0;
    b_go = 1'b0;
    for (k = 0; k < 40 && !b_go; k++) begin
      #1;
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid && bready;
      rsp = bresp;
      sl_seen |= sl;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (b_go) bready <= 1'b0;
    end
    if (!b_go) n_fail++;
    if (!b_go) conclude();
    chk({30'h0, rsp}, {30'h0, er});
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_go, r_go;
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_go = 1'b0;
    for (k = 0; k < 40 && !r_go; k++) begin
      #1;
      ar_go = arvalid && arready;
      r_go = rvalid && rready;
      rd_d = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ar_go) arvalid <= 1'b0;
      if (r_go) rready <= 1'b0;
    end
    if (!r_go) n_fail++;
    if (!r_go) conclude();
    chk(rd_d, ed);
    chk({30'h0, rsp}, {30'h0, er});
  endtask : rd

  task pulse(input caprq_evt_t e, input caprq_line_sel_t ls, input logic [3:0] exp);
    @(posedge aclk);
    evt <= e;
    lsel <= ls;
    @(posedge aclk);
    evt <= '0;
    #1;
    chk({28'h0, sl}, {28'h0, exp});
  endtask : pulse

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h044, 32'h0, 2'h0);
    rd(12'h050, 32'h0, 2'h0);
    rd(12'h054, 32'h0, 2'h0);
    pulse(11'h7FF, 12'h000, 4'h0);
    rd(12'h050, 32'h7FF, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wr(12'h044, 32'hF7FF, 2'h0);
    rd(12'h044, 32'h7FF, 2'h0);
    wr(12'h054, 32'h400, 2'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(12'h050, 32'h7FF, 2'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(12'h050, 32'h0, 2'h0);
    for (int i = 0; i < 11; i++) begin
      p = 2'(i % 4);
      pulse(caprq_evt_t'(11'h1 << i), {6{p}}, 4'h1 << p);
    end
    pulse(11'h005, 12'h005, 4'h2);
    pulse(11'h005, 12'h00C, 4'h9);
    pulse(11'h000, 12'hC00, 4'h0);
    wr(12'h058, 32'h400, 2'h0);
    chk({28'h0, sl_seen}, 32'h8);
    wr(12'h044, 32'h7FE, 2'h0);
    pulse(11'h001, 12'h000, 4'h0);
    pulse(11'h002, 12'h000, 4'h1);
    wr(12'h100, 32'h1, 2'h2);
    rd(12'h100, 32'h0, 2'h2);
    chk({24'h0, n_req}, 32'h0F);
    // Upper lane only: low byte of the enable must survive
    wstrb <= 4'h2;
    wr(12'h044, 32'h1, 2'h0);
    wstrb <= 4'hF;
    rd(12'h044, 32'h0FE, 2'h0);
    pulse(11'h400, 12'h000, 4'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h044, 32'h0, 2'h0);
    chk({31'h0, irq}, 32'h0);
    conclude();
  end
endmodule : capcomp_irq_enable_gating_test

// [bench/caprq_req_sink.sv]
`timescale 1ns/10ps
module caprq_req_sink (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [3:0] service_line,
  output logic     [7:0] n_req
);
  // Coincident lines count once, as the receiver sees one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_req <= 8'h00;
    end else if (service_line != 4'h0) begin
      n_req <= n_req + 8'h01;
    end
  end
endmodule : caprq_req_sink

// [bench/caprq_top_asserts.sv]
`timescale 1ns/10ps
module caprq_top_asserts (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire caprq_pkg::caprq_evt_t  hw_event_set,
  input wire logic [3:0]             service_line,
  input wire logic                   irq
);
  import caprq_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> service_line == 4'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("busy after reset");
  // Soft set fires in the cycle its write response first shows
  a_pulse_cause: assert property (
    service_line != 4'h0 |-> $past(hw_event_set) != '0 || $rose(s_axi_bvalid)) else $error("request without event");
  a_write_answer: assert property (
    s_wr_taken |=> s_wr_answer) else $error("write response timing");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data timing");
  a_resp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:11] == 21'h0) else $error("reserved bits read nonzero");
  a_read_release: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data kept after handshake");
endmodule : caprq_top_asserts

bind caprq_top caprq_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .hw_event_set(hw_event_set),
  .service_line(service_line), .irq(irq));

// [design/caprq_line_router.sv]
`timescale 1ns/10ps
`include "caprq_regs.svh"

module caprq_line_router (
  input  wire logic                      [10:0] set_cond,
  input  wire logic                      [10:0] enable,
  input  wire caprq_pkg::caprq_line_sel_t       line_select,
  output logic                           [3:0]  line_req
);
  import caprq_pkg::*;

  caprq_line_t       evt_sel [11];
  logic        [3:0] evt_req [11];

  function automatic logic [3:0] line_onehot(input caprq_line_t sel);
    line_onehot = 4'h1 << sel;
  endfunction : line_onehot

  // Each event group shares one pointer
  always_comb begin
    evt_sel[`CAPRQ_CH0_RISE_POS] = line_select.ch0_line_select;
    evt_sel[`CAPRQ_CH0_FALL_POS] = line_select.ch0_line_select;
    evt_sel[`CAPRQ_CH1_RISE_POS] = line_select.ch1_line_select;
    evt_sel[`CAPRQ_CH1_FALL_POS] = line_select.ch1_line_select;
    evt_sel[`CAPRQ_CH2_RISE_POS] = line_select.ch2_line_select;
    evt_sel[`CAPRQ_CH2_FALL_POS] = line_select.ch2_line_select;
    evt_sel[`CAPRQ_TMR_A_OM_POS] = line_select.tmr_a_line_select;
    evt_sel[`CAPRQ_TMR_A_PM_POS] = line_select.tmr_a_line_select;
    evt_sel[`CAPRQ_TMR_B_CM_POS] = line_select.tmr_b_line_select;
    evt_sel[`CAPRQ_TMR_B_PM_POS] = line_select.tmr_b_line_select;
    evt_sel[`CAPRQ_TRAP_POS]     = line_select.error_line_select;
  end

  for (genvar i = 0; i < 11; i++) begin : g_evt
    // Disabled events contribute nothing
    assign evt_req[i] = (set_cond[i] && enable[i]) ? line_onehot(evt_sel[i]) : 4'h0;
  end

  // Simultaneous events on one line merge
  always_comb begin
    line_req = 4'h0;
    for (int k = 0; k < 11; k++) begin
      line_req = line_req | evt_req[k];
    end
  end

endmodule : caprq_line_router

// [design/caprq_top.sv]
`timescale 1ns/10ps
`include "caprq_regs.svh"

module caprq_top (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic                      [11:0] s_axi_awaddr,
  input  wire logic                      [2:0]  s_axi_awprot,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic                      [31:0] s_axi_wdata,
  input  wire logic                      [3:0]  s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic                           [1:0]  s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic                      [11:0] s_axi_araddr,
  input  wire logic                      [2:0]  s_axi_arprot,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic                           [31:0] s_axi_rdata,
  output logic                           [1:0]  s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire caprq_pkg::caprq_evt_t            hw_event_set,
  input  wire caprq_pkg::caprq_line_sel_t       line_select,
  output logic                           [3:0]  service_line,
  output logic                                  irq
);
  import caprq_pkg::*;

  // Write address and data are caught separately
  logic        aw_held;
  logic [11:0] aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        b_valid;
  logic [1:0]  b_resp;

  // Read side
  logic        r_valid;
  logic [31:0] r_data;
  logic [1:0]  r_resp;
  logic        ar_fire;
  logic [11:0] rd_word;

  // Write decode
  logic        wr_fire;
  logic [11:0] wr_word;
  logic [15:0] wr_lanes;
  logic [15:0] wr_bits;
  logic        wr_hit_enable;
  logic        wr_hit_status;
  logic        wr_hit_mask;
  logic        wr_hit_swset;
  logic        wr_mapped;

  // Register state
  logic [15:0] event_irq_enable;
  logic [15:0] event_flag_status;
  logic [15:0] event_irq_mask;
  logic [15:0] next_enable;
  logic [15:0] next_mask;
  logic [15:0] status_clr;
  logic [15:0] sw_set;
  caprq_evt_t  set_cond;
  logic [3:0]  next_service_line;
  logic        next_irq;

  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  function automatic logic [11:0] word_addr(input logic [11:0] addr);
    word_addr = {addr[11:2], 2'h0};
  endfunction : word_addr

  assign s_axi_awready = !aw_held && !b_valid;
  assign s_axi_wready  = !w_held && !b_valid;
  assign s_axi_arready = !r_valid;
  assign s_axi_bvalid  = b_valid;
  assign s_axi_bresp   = b_resp;
  assign s_axi_rvalid  = r_valid;
  assign s_axi_rdata   = r_data;
  assign s_axi_rresp   = r_resp;

  // Write fires once both halves are held
  assign wr_fire  = aw_held && w_held && !b_valid;
  assign wr_word  = word_addr(aw_addr);
  assign wr_lanes = lane_mask(w_strb);
  assign wr_bits  = w_data[15:0] & wr_lanes & `CAPRQ_IMPL_BITS;
  assign ar_fire  = s_axi_arvalid && !r_valid;
  assign rd_word  = word_addr(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    wr_hit_enable = 1'b0;
    wr_hit_status = 1'b0;
    wr_hit_mask   = 1'b0;
    wr_hit_swset  = 1'b0;
    wr_mapped     = 1'b1;
    if (wr_word == `CAPRQ_ENABLE_OFFSET) begin
      wr_hit_enable = 1'b1;
    end else if (wr_word == `CAPRQ_STATUS_OFFSET) begin
      wr_hit_status = 1'b1;
    end else if (wr_word == `CAPRQ_MASK_OFFSET) begin
      wr_hit_mask = 1'b1;
    end else if (wr_word == `CAPRQ_SWSET_OFFSET) begin
      wr_hit_swset = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_valid <= 1'b0;
      b_resp  <= `CAPRQ_RESP_OKAY;
    end else if (wr_fire) begin
      b_valid <= 1'b1;
      b_resp  <= wr_mapped ? `CAPRQ_RESP_OKAY : `CAPRQ_RESP_SLVERR;
    end else if (s_axi_bready) begin
      b_valid <= 1'b0;
    end
  end

  // Byte lanes merge; unused and reserved bits forced to zero
  always_comb begin
    next_enable = ((event_irq_enable & ~wr_lanes) | (w_data[15:0] & wr_lanes)) & `CAPRQ_IMPL_BITS;
    next_mask   = ((event_irq_mask & ~wr_lanes) | (w_data[15:0] & wr_lanes)) & `CAPRQ_IMPL_BITS;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_irq_enable <= `CAPRQ_ENABLE_RESET;
    end else if (wr_fire && wr_hit_enable) begin
      event_irq_enable <= next_enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_irq_mask <= `CAPRQ_MASK_RESET;
    end else if (wr_fire && wr_hit_mask) begin
      event_irq_mask <= next_mask;
    end
  end

  // Software set and clear strobes, one cycle each
  always_comb begin
    sw_set     = 16'h0000;
    status_clr = 16'h0000;
    if (wr_fire && wr_hit_swset) begin
      sw_set = wr_bits;
    end
    if (wr_fire && wr_hit_status) begin
      status_clr = wr_bits;
    end
  end

  // Software set enters the same path as hardware
  assign set_cond = hw_event_set | sw_set[10:0];

  // Set beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_flag_status <= `CAPRQ_STATUS_RESET;
    end else begin
      event_flag_status <= (event_flag_status & ~status_clr) | {5'h00, set_cond};
    end
  end

  caprq_line_router u_router (
    .set_cond    (set_cond),
    .enable      (event_irq_enable[10:0]),
    .line_select (line_select),
    .line_req    (next_service_line)
  );

  // Pulse per set condition, not the stored flag level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      service_line <= 4'h0;
    end else begin
      service_line <= next_service_line;
    end
  end

  assign next_irq = |(event_flag_status & event_irq_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_valid <= 1'b0;
      r_data  <= 32'h0000_0000;
      r_resp  <= `CAPRQ_RESP_OKAY;
    end else if (ar_fire) begin
      r_valid <= 1'b1;
      r_resp  <= `CAPRQ_RESP_OKAY;
      if (rd_word == `CAPRQ_ENABLE_OFFSET) begin
        r_data <= {16'h0000, event_irq_enable & `CAPRQ_IMPL_BITS};
      end else if (rd_word == `CAPRQ_STATUS_OFFSET) begin
        r_data <= {16'h0000, event_flag_status};
      end else if (rd_word == `CAPRQ_MASK_OFFSET) begin
        r_data <= {16'h0000, event_irq_mask};
      end else if (rd_word == `CAPRQ_SWSET_OFFSET) begin
        r_data <= 32'h0000_0000;
      end else begin
        r_data <= 32'h0000_0000;
        r_resp <= `CAPRQ_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      r_valid <= 1'b0;
    end
  end

endmodule : caprq_top

// [inc/caprq_pkg.sv]
package caprq_pkg;

  typedef logic [1:0] caprq_line_t;

  // Event vector, bit 10 first
  typedef struct packed {
    logic trap_flag;
    logic tmr_b_period_flag;
    logic tmr_b_compare_flag;
    logic tmr_a_period_flag;
    logic tmr_a_onematch_flag;
    logic ch2_fall_flag;
    logic ch2_rise_flag;
    logic ch1_fall_flag;
    logic ch1_rise_flag;
    logic ch0_fall_flag;
    logic ch0_rise_flag;
  } caprq_evt_t;

  // Node pointers per source group
  typedef struct packed {
    caprq_line_t error_line_select;
    caprq_line_t tmr_b_line_select;
    caprq_line_t tmr_a_line_select;
    caprq_line_t ch2_line_select;
    caprq_line_t ch1_line_select;
    caprq_line_t ch0_line_select;
  } caprq_line_sel_t;

endpackage : caprq_pkg

// [inc/caprq_regs.svh]
`ifndef CAPRQ_REGS_SVH
`define CAPRQ_REGS_SVH

// Register byte offsets
`define CAPRQ_ENABLE_OFFSET   12'h044
`define CAPRQ_STATUS_OFFSET   12'h050
`define CAPRQ_MASK_OFFSET     12'h054
`define CAPRQ_SWSET_OFFSET    12'h058

// Reset values
`define CAPRQ_ENABLE_RESET    16'h0000
`define CAPRQ_STATUS_RESET    16'h0000
`define CAPRQ_MASK_RESET      16'h0000

// Implemented bits; bit 11 reserved, 15:12 not in this block
`define CAPRQ_IMPL_BITS       16'h07FF
`define CAPRQ_RESERVED_POS    11

// Field positions
`define CAPRQ_CH0_RISE_POS    0
`define CAPRQ_CH0_FALL_POS    1
`define CAPRQ_CH1_RISE_POS    2
`define CAPRQ_CH1_FALL_POS    3
`define CAPRQ_CH2_RISE_POS    4
`define CAPRQ_CH2_FALL_POS    5
`define CAPRQ_TMR_A_OM_POS    6
`define CAPRQ_TMR_A_PM_POS    7
`define CAPRQ_TMR_B_CM_POS    8
`define CAPRQ_TMR_B_PM_POS    9
`define CAPRQ_TRAP_POS        10

// Bus responses
`define CAPRQ_RESP_OKAY       2'h0
`define CAPRQ_RESP_SLVERR     2'h2

`endif
